// ===== design/analog_input_scaling_curve.sv
// One analog input scaling curve: source select, filter, curve map, supervision.
// Contract
// [R1] Channel scaling enable defaults off; disabled channel is not processed.
// [R2] Curve enable defaults off and gates curve and its input measurement.
// [R3] Input chosen from mA, DI voltage or RTD sources; first mA after reset.
// [R4] Optional input averaging, off by default, applied before the curve.
// [R5] Filter time constant in 5 ms steps, default 1 s, used only when filtering.
// [R6] Out-of-range supervision enable, default off; flag only while enabled.
// [R7] Flag when input is below minimum limit; limit default 0.
// [R8] Flag when input exceeds maximum limit; limit default 0.
// [R9] Received input value readable as monitoring output.
// [R10] Scaled output value readable as monitoring output.
// [R11] Filter is first-order low-pass governed by the time constant.
// [R12] On lost input, hold last valid cycle value.
// [R13] Input re-measured once per update cycle; 5 ms steps, default 150 ms.
// [R14] Linear between two points by default; up to twenty points when enabled.
// [R15] Flag clears on next update once input is back within limits inclusive.
// [R16] Disabled curve or channel keeps output and flag inactive and frozen.
`default_nettype none
module analog_input_scaling_curve
    import scaling_curve_pkg::*;
#(
    // Only a bench shortens the step; silicon must keep the 5 ms default.
    parameter int STEP_LEN = STEP_CYCLES // Clocks per update step
)
(
    input  wire logic                      clock,            // 40 MHz clock
    input  wire logic                      rst,              // Async reset, active high
    input  wire logic                      channel_enable,   // Channel scaling enable
    input  wire logic                      curve_enable,     // Curve enable
    input  wire logic        [SOURCE_W-1:0] source_select,   // Selected source index
    input  wire logic                      source_write,     // Load source_select
    input  wire logic signed [VALUE_W-1:0] source_value [SOURCE_COUNT], // All measurements
    input  wire logic        [SOURCE_COUNT-1:0] source_valid, // Measurement present
    input  wire logic                      filter_enable,    // Averaging on
    input  wire logic        [19:0]        filter_tc,        // Time constant, 5 ms steps
    input  wire logic                      filter_tc_write,  // Load filter_tc
    input  wire logic        [11:0]        cycle_len,        // Update cycle, 5 ms steps
    input  wire logic                      cycle_len_write,  // Load cycle_len
    input  wire logic                      range_enable,     // Out-of-range supervision on
    input  wire logic signed [VALUE_W-1:0] limit_min,        // Minimum input limit
    input  wire logic signed [VALUE_W-1:0] limit_max,        // Maximum input limit
    input  wire logic                      limits_write,     // Load both limits
    input  wire logic        [POINT_IDX_W-1:0] point_used,   // Highest point in use (1..19)
    input  wire logic signed [VALUE_W-1:0] point_in  [POINT_COUNT], // Point input values
    input  wire logic signed [VALUE_W-1:0] point_out [POINT_COUNT], // Point output values
    output logic signed      [VALUE_W-1:0] curve_input,      // Input seen by curve
    output logic signed      [VALUE_W-1:0] curve_output,     // Scaled output
    output logic                           curve_out_of_range_flag, // Input outside limits
    output logic                           update_done       // Pulse per finished update
);
    logic        [SOURCE_W-1:0]    source_q;
    logic        [19:0]            filter_tc_q;
    logic        [11:0]            cycle_len_q;
    logic signed [VALUE_W-1:0]     limit_min_q;
    logic signed [VALUE_W-1:0]     limit_max_q;
    logic signed [VALUE_W-1:0]     held_q;
    logic                          held_ok_q;
    logic                          filter_was_on_q;
    logic        [POINT_IDX_W-1:0] seg_q;
    curve_state_t                  state_q;
    logic                          active;
    logic                          tick;
    logic signed [VALUE_W-1:0]     avg;
    logic signed [VALUE_W-1:0]     x;
    logic                          filter_load;
    logic                          filter_step;
    logic        [POINT_IDX_W-1:0] last_seg;

    assign active = channel_enable && curve_enable; // [R1] [R2]

    // Settings held in the block with documented defaults.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            source_q    <= SOURCE_RESET;    // [R3]
            filter_tc_q <= FILTER_TC_RESET; // [R5]
            cycle_len_q <= CYCLE_LEN_RESET; // [R13]
            limit_min_q <= LIMIT_MIN_RESET; // [R7]
            limit_max_q <= LIMIT_MAX_RESET; // [R8]
        end
        else
        begin
            if (source_write)
                source_q <= source_select; // [R3]
            if (filter_tc_write)
                filter_tc_q <= filter_tc;
            if (cycle_len_write)
                cycle_len_q <= cycle_len;
            if (limits_write)
            begin
                limit_min_q <= limit_min;
                limit_max_q <= limit_max;
            end
        end
    end

    update_tick #(.STEP_LEN(STEP_LEN)) u_tick
    (
        .clock     (clock),
        .rst       (rst),
        .run       (active),
        .cycle_len (cycle_len_q),
        .tick      (tick)
    );

    // Sample the selected source; keep the last good value on loss.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            held_q    <= '0;
            held_ok_q <= 1'b0;
        end
        else if (state_q == ST_SAMPLE && source_valid[source_q])
        begin
            held_q    <= source_value[source_q];
            held_ok_q <= 1'b1;
        end // [R12]
    end

    // The filter restarts from the raw value when first switched on, so a
    // stale average from an earlier configuration does not leak through.
    assign filter_load = (state_q == ST_FILTER) && !filter_was_on_q;
    assign filter_step = (state_q == ST_FILTER) && filter_was_on_q && filter_enable; // [R4] [R5]

    avg_filter u_filter
    (
        .clock    (clock),
        .rst      (rst),
        .load     (filter_load),
        .step     (filter_step),
        .raw      (held_q),
        .tc_steps (filter_tc_q),
        .dt_steps (cycle_len_q),
        .avg      (avg)
    );

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            filter_was_on_q <= 1'b0;
        else if (!active || !filter_enable)
            filter_was_on_q <= 1'b0;
        else if (state_q == ST_FILTER)
            filter_was_on_q <= 1'b1;
    end

    assign x = filter_enable ? avg : held_q; // [R4]
    assign last_seg = (point_used == 5'h00) ? 5'h00
                    : (point_used > 5'h13) ? 5'h12 : point_used - 5'h01;

    // Linear interpolation on segment s, clamped ends extrapolate linearly.
    function automatic logic signed [VALUE_W-1:0] interp(input logic [POINT_IDX_W-1:0] s,
                                                        input logic signed [VALUE_W-1:0] v);
        logic signed [79:0] dx;
        logic signed [79:0] dy;
        logic signed [79:0] num;
        dx  = 80'(point_in[s + 5'h01]) - 80'(point_in[s]);
        dy  = 80'(point_out[s + 5'h01]) - 80'(point_out[s]);
        num = (80'(v) - 80'(point_in[s])) * dy;
        if (dx == 80'sd0)
            interp = point_out[s];
        else
            interp = clip_value(80'(point_out[s]) + num / dx);
    endfunction

    // Update sequencer: sample, filter, find segment, map, publish.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_q     <= ST_IDLE;
            seg_q       <= 5'h00;
            update_done <= 1'b0;
        end
        else
        begin
            update_done <= 1'b0;
            if (!active)
                state_q <= ST_IDLE; // [R16]
            else
            begin
                unique case (state_q)
                    ST_IDLE:
                    begin
                        if (tick)
                            state_q <= ST_SAMPLE; // [R13]
                    end
                    ST_SAMPLE:
                        state_q <= ST_FILTER;
                    ST_FILTER:
                    begin
                        seg_q   <= 5'h00;
                        state_q <= ST_SEARCH;
                    end
                    ST_SEARCH:
                    begin
                        // One segment per cycle keeps the comparator count low.
                        if (seg_q < last_seg && x > point_in[seg_q + 5'h01]) // [R14]
                            seg_q <= seg_q + 5'h01;
                        else
                            state_q <= ST_MAP;
                    end
                    ST_MAP:
                        state_q <= ST_DONE;
                    ST_DONE:
                    begin
                        update_done <= 1'b1;
                        state_q     <= ST_IDLE;
                    end
                    default:
                        state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Monitoring values are published only after a good sample exists.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            curve_input  <= '0;
            curve_output <= '0;
        end
        else if (!active)
        begin
            curve_output <= '0; // [R16]
        end
        else if (state_q == ST_MAP && held_ok_q)
        begin
            curve_input  <= x;                 // [R9]
            curve_output <= interp(seg_q, x);  // [R10] [R14]
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            curve_out_of_range_flag <= 1'b0;
        else if (!active || !range_enable)
            curve_out_of_range_flag <= 1'b0; // [R6] [R16]
        else if (state_q == ST_MAP && held_ok_q)
            curve_out_of_range_flag <= (x < limit_min_q) || (x > limit_max_q); // [R7] [R8] [R15]
    end

    sequence s_map_low;
        state_q == ST_MAP && held_ok_q && range_enable && active && x < limit_min_q;
    endsequence

    sequence s_map_high;
        state_q == ST_MAP && held_ok_q && range_enable && active && x > limit_max_q;
    endsequence

    a_flag_needs_super: assert property (@(posedge clock) disable iff (rst) // [R6]
        !range_enable |=> !curve_out_of_range_flag)
        else $error("Out-of-range flag set without supervision.");

    a_low_sets_flag: assert property (@(posedge clock) disable iff (rst) // [R7]
        s_map_low ##1 (range_enable && active) |-> curve_out_of_range_flag)
        else $error("Input below minimum did not set flag.");

    a_high_sets_flag: assert property (@(posedge clock) disable iff (rst) // [R8]
        s_map_high ##1 (range_enable && active) |-> curve_out_of_range_flag)
        else $error("Input above maximum did not set flag.");

    a_flag_clears_inside: assert property (@(posedge clock) disable iff (rst) // [R15]
        state_q == ST_MAP && held_ok_q && x >= limit_min_q && x <= limit_max_q
        |=> !curve_out_of_range_flag)
        else $error("Flag stayed set with input inside limits.");

    a_disabled_quiet: assert property (@(posedge clock) disable iff (rst) // [R16]
        !active |=> (curve_output == '0) && !curve_out_of_range_flag)
        else $error("Disabled curve drives output or flag.");

    a_channel_gates: assert property (@(posedge clock) disable iff (rst) // [R1]
        !channel_enable |=> state_q == ST_IDLE)
        else $error("Disabled channel is being processed.");

    a_curve_gates: assert property (@(posedge clock) disable iff (rst) // [R2]
        !curve_enable |=> !update_done)
        else $error("Disabled curve completed an update.");

    a_input_published: assert property (@(posedge clock) disable iff (rst) // [R9]
        state_q == ST_MAP && held_ok_q && active |=> curve_input == $past(x))
        else $error("Curve input monitor not updated.");

    a_update_sequence: assert property (@(posedge clock) disable iff (rst) // [R13]
        tick && state_q == ST_IDLE && active ##1 active [*3] |-> state_q == ST_SEARCH)
        else $error("Update did not start on the cycle tick.");

    a_hold_on_loss: assert property (@(posedge clock) disable iff (rst) // [R12]
        state_q == ST_SAMPLE && !source_valid[source_q] |=> held_q == $past(held_q))
        else $error("Held value changed while input lost.");

    a_source_reset: assert property (@(posedge clock) // [R3]
        $fell(rst) |-> source_q == SOURCE_RESET)
        else $error("Source select not at first milliamp input after reset.");

    a_search_in_range: assert property (@(posedge clock) disable iff (rst) // [R14]
        state_q == ST_SEARCH |-> seg_q <= last_seg)
        else $error("Segment search ran past the last used point.");
endmodule
`default_nettype wire

// ===== design/avg_filter.sv
// First-order low-pass averaging filter evaluated once per update cycle.
`default_nettype none
module avg_filter
    import scaling_curve_pkg::*;
(
    input  wire logic                      clock,    // 40 MHz clock
    input  wire logic                      rst,      // Async reset, active high
    input  wire logic                      load,     // Take raw value as filter state
    input  wire logic                      step,     // Advance filter by one update
    input  wire logic signed [VALUE_W-1:0] raw,      // New sample
    input  wire logic        [19:0]        tc_steps, // Time constant in 5 ms steps
    input  wire logic        [11:0]        dt_steps, // Update period in 5 ms steps
    output logic signed      [VALUE_W-1:0] avg       // Filtered value
);
    // y += (x - y) * dt / (tc + dt): the discrete form of 1/(1+s/wc).
    // A divider is costly but runs only once per update, so a
    // single-cycle combinational divide is accepted for clarity.
    logic signed [79:0] diff;
    logic signed [79:0] prod;
    logic signed [79:0] den;
    logic signed [79:0] inc;

    assign diff = 80'(raw) - 80'(avg);
    assign prod = diff * $signed({68'h0, dt_steps});
    assign den  = $signed({60'h0, tc_steps}) + $signed({68'h0, dt_steps});
    assign inc  = (den == 80'sd0) ? diff : prod / den;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            avg <= '0;
        else if (load)
            avg <= raw;
        else if (step)
            avg <= clip_value(80'(avg) + inc); // [R11]
    end

    a_filter_moves: assert property (@(posedge clock) disable iff (rst) // [R11]
        step && !load && (raw > avg) && (inc > 0) |=> (avg > $past(avg)))
        else $error("Filter did not move toward input.");
endmodule
`default_nettype wire

// ===== design/update_tick.sv
// Update cycle timer: one pulse per configured number of 5 ms steps.
`default_nettype none
module update_tick
    import scaling_curve_pkg::*;
#(
    parameter int STEP_LEN = STEP_CYCLES // Clocks per 5 ms step
)
(
    input  wire logic        clock,     // 40 MHz clock
    input  wire logic        rst,       // Async reset, active high
    input  wire logic        run,       // Counting allowed
    input  wire logic [11:0] cycle_len, // Cycle length in 5 ms steps
    output logic             tick       // One-cycle pulse per update
);
    logic [17:0] step_q;
    logic [11:0] count_q;
    logic        step_end;
    logic [11:0] len_eff;

    assign step_end = (step_q == 18'(STEP_LEN - 1));
    // A zero length would wrap to a 4096-step cycle; treat it as one step.
    assign len_eff = (cycle_len == 12'h000) ? 12'h001 : cycle_len;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            step_q <= 18'h00000;
        else if (!run || step_end)
            step_q <= 18'h00000;
        else
            step_q <= step_q + 18'h00001;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            count_q <= 12'h000;
            tick    <= 1'b0;
        end
        else
        begin
            tick <= 1'b0;
            if (!run)
                count_q <= 12'h000;
            else if (step_end)
            begin
                if (count_q >= len_eff - 12'h001)
                begin
                    count_q <= 12'h000;
                    tick    <= 1'b1; // [R13]
                end
                else
                    count_q <= count_q + 12'h001;
            end
        end
    end
endmodule
`default_nettype wire

// ===== include/scaling_curve_pkg.sv
// Shared constants and types for one analog input scaling curve channel.
`default_nettype none
package scaling_curve_pkg;
    // Values are signed fixed point in units of 0.00001 (1 LSB = 1e-5).
    localparam int VALUE_W = 40;
    localparam int POINT_COUNT = 20;
    localparam int POINT_IDX_W = 5;
    localparam int SOURCE_W = 6;
    localparam logic [SOURCE_W-1:0] SOURCE_RESET = 6'h00; // First milliamp source.
    localparam int SOURCE_COUNT = 64;

    localparam int CLOCK_HZ = 40000000;
    localparam int FILTER_STEP_US = 5000;
    localparam logic [19:0] FILTER_TC_RESET = 20'h000C8; // 200 steps of 5 ms = 1 s.
    localparam int CYCLE_STEP_US = 5000;
    localparam logic [11:0] CYCLE_LEN_RESET = 12'h01E; // 30 steps of 5 ms = 150 ms.
    localparam int STEP_CYCLES = (CLOCK_HZ / 1000000) * CYCLE_STEP_US;

    localparam logic [VALUE_W-1:0] LIMIT_MIN_RESET = 40'h0000000000;
    localparam logic [VALUE_W-1:0] LIMIT_MAX_RESET = 40'h0000000000;

    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b000,
        ST_SAMPLE = 3'b001,
        ST_FILTER = 3'b010,
        ST_SEARCH = 3'b011,
        ST_MAP    = 3'b100,
        ST_DONE   = 3'b101
    } curve_state_t;

    // Saturating clip of a wide signed value to the value width.
    function automatic logic signed [VALUE_W-1:0] clip_value(input logic signed [79:0] v);
        logic signed [79:0] hi;
        logic signed [79:0] lo;
        hi = 80'sd549755813887;
        lo = -80'sd549755813888;
        if (v > hi)
            clip_value = hi[VALUE_W-1:0];
        else if (v < lo)
            clip_value = lo[VALUE_W-1:0];
        else
            clip_value = v[VALUE_W-1:0];
    endfunction
endpackage
`default_nettype wire

// ===== sim/meas_source_model.sv
// Behavioural model of the measurement cards that feed the scaling curve.
`default_nettype none
module meas_source_model
    import scaling_curve_pkg::*;
(
    input  wire logic                      clock,        // Bench clock
    output var logic signed [VALUE_W-1:0]  source_value [SOURCE_COUNT], // Measurements
    output var logic [SOURCE_COUNT-1:0]    source_valid  // Measurement present
);
    timeunit 1ns;
    timeprecision 1ps;

    logic signed [VALUE_W-1:0] level [SOURCE_COUNT];
    logic        [VALUE_W-1:0] junk;

    task automatic set_meas(input int idx, input logic signed [VALUE_W-1:0] v, input logic ok);
        level[idx] = v;
        source_valid[idx] = ok;
    endtask

    initial
    begin
        junk = 40'h5A5A5A5A5A;
        source_valid = '1;
        for (int i = 0; i < SOURCE_COUNT; i++)
            level[i] = 40'h0000000000;
    end

    // A lost input shows a value that moves every cycle, so a design that keeps
    // sampling the line instead of holding cannot pass by luck.
    always @(negedge clock)
        junk <= {junk[38:0], ~junk[39]} ^ 40'h0000000001;

    always_comb
        for (int i = 0; i < SOURCE_COUNT; i++)
            source_value[i] = source_valid[i] ? level[i] : junk;
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking testbench for one analog input scaling curve channel.
`default_nettype none
module tb
    import scaling_curve_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                      clock;
    logic                      rst;
    logic                      channel_enable;
    logic                      curve_enable;
    logic        [SOURCE_W-1:0] src_sel;
    logic                      source_write;
    logic signed [VALUE_W-1:0] src_val [SOURCE_COUNT];
    logic [SOURCE_COUNT-1:0]   src_ok;
    logic                      filter_enable;
    logic        [19:0]        filter_tc;
    logic                      filter_tc_write;
    logic        [11:0]        cycle_len;
    logic                      cycle_len_write;
    logic                      range_enable;
    logic signed [VALUE_W-1:0] limit_min;
    logic signed [VALUE_W-1:0] limit_max;
    logic                      limits_write;
    logic [POINT_IDX_W-1:0]    point_used;
    logic signed [VALUE_W-1:0] p_in  [POINT_COUNT];
    logic signed [VALUE_W-1:0] p_out [POINT_COUNT];
    logic signed [VALUE_W-1:0] curve_input;
    logic signed [VALUE_W-1:0] curve_output;
    logic                      flag;
    logic                      update_done;
    int                        num_errors;
    int                        checked;
    int                        gap;
    int                        n;
    longint                    x;
    time                       last_done;

    // A short step keeps the run brief; the update waits, spacing checks and timeout below scale with it.
    localparam int STEP_SIM = 500;

    meas_source_model i_src (.clock(clock), .source_value(src_val), .source_valid(src_ok));

    analog_input_scaling_curve #(.STEP_LEN(STEP_SIM)) i_dut (
        .clock(clock), .rst(rst), .channel_enable(channel_enable),
        .curve_enable(curve_enable), .source_select(src_sel), .source_write(source_write),
        .source_value(src_val), .source_valid(src_ok), .filter_enable(filter_enable),
        .filter_tc(filter_tc), .filter_tc_write(filter_tc_write), .cycle_len(cycle_len),
        .cycle_len_write(cycle_len_write), .range_enable(range_enable),
        .limit_min(limit_min), .limit_max(limit_max), .limits_write(limits_write),
        .point_used(point_used), .point_in(p_in), .point_out(p_out),
        .curve_input(curve_input), .curve_output(curve_output),
        .curve_out_of_range_flag(flag), .update_done(update_done));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Piecewise linear reference; the chosen points keep every slope exact.
    function automatic longint expect_out(input longint v);
        int k;
        k = 0;
        while (k + 1 < int'(point_used) && v > p_in[k + 1])
            k++;
        return p_out[k] + (v - p_in[k]) * (p_out[k + 1] - p_out[k]) / (p_in[k + 1] - p_in[k]);
    endfunction

    function automatic logic expect_flag(input longint v);
        return range_enable && (v < limit_min || v > limit_max);
    endfunction

    task automatic chk(input logic [VALUE_W-1:0] got, input logic [VALUE_W-1:0] exp,
                       input string what);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic pulse(ref logic strobe);
        strobe = 1'b1;
        @(negedge clock);
        strobe = 1'b0;
    endtask

    // Waits for one finished update and records the spacing from the previous one.
    task automatic wait_update();
        int k;
        k = 0;
        @(negedge clock);
        while (update_done !== 1'b1 && k < 32 * STEP_SIM)
        begin
            @(negedge clock);
            k++;
        end
        chk({39'h0, update_done}, 40'h0000000001, "update pulse");
        gap = int'(($time - last_done) / 25);
        last_done = $time;
    endtask

    task automatic run_upd(input int src, input longint v, input logic ok, input longint exp_in);
        i_src.set_meas(src, v[VALUE_W-1:0], ok);
        wait_update();
        chk(curve_input, exp_in[VALUE_W-1:0], "curve input");
        chk(curve_output, 40'(expect_out(exp_in)), "curve output");
        chk({39'h0, flag}, {39'h0, expect_flag(exp_in)}, "range flag");
    endtask

    initial
    begin
        rst = 1'b1;
        {channel_enable, curve_enable, source_write, filter_enable} = 4'h0;
        {filter_tc_write, cycle_len_write, range_enable, limits_write} = 4'h0;
        src_sel = 6'h00;
        filter_tc = 20'h00001;
        cycle_len = 12'h001;
        limit_min = 40'h0000000000;
        limit_max = 40'h0000000000;
        point_used = 5'h01;
        for (int i = 0; i < POINT_COUNT; i++)
        begin
            p_in[i] = 40'sd1000 * i;
            p_out[i] = (i < 2) ? 40'sd5000 * i : 40'sd4000 * i + 40'sd1000;
        end
        num_errors = 0;
        checked = 0;
        void'($urandom(98));
        repeat (3) @(negedge clock);
        rst = 1'b0;
        pulse(filter_tc_write);
        // Curve on but channel off: a whole default cycle must pass with no update.
        curve_enable = 1'b1;
        n = 0;
        repeat (31 * STEP_SIM)
        begin
            @(negedge clock);
            if (update_done === 1'b1)
                n++;
        end
        chk(40'(n), 40'h0000000000, "updates while off");
        chk(curve_output, 40'h0000000000, "output while off");
        channel_enable = 1'b1;
        last_done = $time;
        // Limits still at 0, so only the disabled supervision keeps the flag low.
        x = $urandom_range(1000, 1);
        run_upd(0, x, 1'b1, x);
        chk(40'(gap), 40'(int'(CYCLE_LEN_RESET) * STEP_SIM + 6), "default cycle");
        pulse(cycle_len_write);
        range_enable = 1'b1;
        limit_min = 40'sd100;
        limit_max = 40'sd900;
        pulse(limits_write);
        x = $urandom_range(99, 0);
        run_upd(0, x, 1'b1, x);
        x = $urandom_range(1000, 901);
        run_upd(0, x, 1'b1, x);
        run_upd(0, 900, 1'b1, 900);
        run_upd(0, 100, 1'b1, 100);
        chk(40'(gap), 40'(STEP_SIM), "update spacing");
        i_src.set_meas(0, 40'sd999, 1'b1);
        src_sel = 6'h05;
        pulse(source_write);
        x = $urandom_range(900, 100);
        run_upd(5, x, 1'b1, x);
        run_upd(5, 12345, 1'b0, x);
        filter_enable = 1'b1;
        run_upd(5, 200, 1'b1, 200);
        // Time constant equals the update period, so each step halves the gap.
        run_upd(5, 600, 1'b1, 400);
        filter_enable = 1'b0;
        point_used = 5'h02;
        limit_max = 40'sd1000;
        pulse(limits_write);
        x = $urandom_range(2000, 1001);
        run_upd(5, x, 1'b1, x);
        curve_enable = 1'b0;
        repeat (3) @(negedge clock);
        chk(curve_output, 40'h0000000000, "output after disable");
        chk({39'h0, flag}, 40'h0000000000, "flag after disable");
        wrap_up();
    end

    initial
    begin
        repeat (120 * STEP_SIM) @(posedge clock);
        num_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
